/* bench/mouse_input_props.sv */
// Port-level assertions for the mouse input collector
`timescale 1ns/1ps
`default_nettype none
module mouse_input_props
    import mouse_pkg::*;
#(
    parameter int DEB_CYCLES    = DEBOUNCE_CYC,
    parameter int LED_ON_CYCLES = LED_ON_CYC
) (
    // Clocks and reset
    input wire logic                      clk,
    input wire logic                      sys_rst,
    input wire logic                      link_clk,
    // Pins
    input wire logic [NUM_BUTTONS-1:0]    btn_n,
    input wire logic [NUM_BUTTONS-1:0]    pullup_en,
    input wire logic                      wheel_led,
    input wire spi_out_t                  spi_out,
    // Results
    input wire logic [NUM_BUTTONS-1:0]    buttons,
    input wire logic signed [WHEEL_W-1:0] wheel_count,
    input wire motion_report_t            report,
    input wire logic                      report_valid,
    input wire logic                      sleeping
);
    logic [NUM_BUTTONS-1:0] s1_q, s1_d, s2_q, s2_d, l_q, l_d, prev_q, prev_d;
    int                     st_q [NUM_BUTTONS], st_d [NUM_BUTTONS];
    int                     h_q [NUM_BUTTONS], h_d [NUM_BUTTONS];
    int                     run_q, run_d, ed_q, ed_d;
    logic                   deb_bad, pol_bad, sp_q, sp_d;

    // Level history of the button pins and light pulse length
    always_comb begin
        s1_d = btn_n;
        s2_d = s1_q;
        l_d = s2_q;
        prev_d = buttons;
        deb_bad = 1'b0;
        pol_bad = 1'b0;
        run_d = wheel_led ? run_q + 1 : 0;
        for (int i = 0; i < NUM_BUTTONS; i++) begin
            st_d[i] = (s1_q[i] != s2_q[i]) ? 0 : (st_q[i] < DEB_CYCLES ? st_q[i] + 1 : st_q[i]);
            h_d[i] = st_q[i];
            if (buttons[i] != prev_q[i] && h_q[i] < DEB_CYCLES - 2) deb_bad = 1'b1;
            if (buttons[i] != prev_q[i] && buttons[i] == l_q[i]) pol_bad = 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            {s1_q, s2_q, l_q, prev_q} <= {{3{RELEASED_N}}, 3'h0};
            st_q <= '{default: 0};
            h_q <= '{default: 0};
            run_q <= 0;
        end else begin
            {s1_q, s2_q, l_q, prev_q} <= {s1_d, s2_d, l_d, prev_d};
            st_q <= st_d;
            h_q <= h_d;
            run_q <= run_d;
        end
    end

    // Serial clock rises counted within one select
    always_comb begin
        sp_d = spi_out.sclk;
        ed_d = spi_out.cs_n ? 0 : ed_q + ((spi_out.sclk && !sp_q) ? 1 : 0);
    end
    always_ff @(posedge link_clk) begin
        if (sys_rst) begin
            sp_q <= 1'b0;
            ed_q <= 0;
        end else begin
            sp_q <= sp_d;
            ed_q <= ed_d;
        end
    end

    a_pullups_on: assert property (@(posedge clk) disable iff (sys_rst)
        pullup_en == PULLUP_ALL) else $error("pull-ups not all enabled");
    a_report_hold: assert property (@(posedge clk) disable iff (sys_rst)
        $changed(report) |-> report_valid) else $error("report changed without valid");
    a_led_dark_sleep: assert property (@(posedge clk) disable iff (sys_rst)
        sleeping |-> !wheel_led) else $error("wheel light on while sleeping");
    a_led_width: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(wheel_led) |-> run_q == LED_ON_CYCLES) else $error("wheel light pulse width wrong");
    a_btn_debounce: assert property (@(posedge clk) disable iff (sys_rst)
        !deb_bad) else $error("button accepted before steady interval");
    a_btn_polarity: assert property (@(posedge clk) disable iff (sys_rst)
        !pol_bad) else $error("button state does not follow inverted pin");
    a_wheel_step: assert property (@(posedge clk) disable iff (sys_rst)
        $changed(wheel_count) |-> (wheel_count == $past(wheel_count) + 8'sd1)
        || (wheel_count == $past(wheel_count) - 8'sd1)) else $error("wheel count jumped");
    a_wheel_sleep: assert property (@(posedge clk) disable iff (sys_rst)
        sleeping |=> $stable(wheel_count)) else $error("wheel counted while sleeping");
    a_spi_bytes: assert property (@(posedge link_clk) disable iff (sys_rst)
        $rose(spi_out.cs_n) |-> ed_q == 32) else $error("select frame not four bytes");
    a_sclk_idle: assert property (@(posedge link_clk) disable iff (sys_rst)
        spi_out.cs_n |-> !spi_out.sclk) else $error("serial clock active while deselected");
endmodule : mouse_input_props

bind mouse_input_collector mouse_input_props #(
    .DEB_CYCLES   (DEB_CYCLES),
    .LED_ON_CYCLES(LED_ON_CYCLES)
) u_mouse_input_props (
    .clk(clk), .sys_rst(sys_rst), .link_clk(link_clk), .btn_n(btn_n),
    .pullup_en(pullup_en), .wheel_led(wheel_led), .spi_out(spi_out), .buttons(buttons),
    .wheel_count(wheel_count), .report(report), .report_valid(report_valid),
    .sleeping(sleeping)
);
`default_nettype wire

/* bench/sensor_model.sv */
// Behavioural navigation sensor on the serial side of the collector
`timescale 1ns/1ps
`default_nettype none
module sensor_model
    import mouse_pkg::*;
(
    // Link clock and serial pins
    input  wire logic     link_clk,
    input  wire spi_out_t spi_out,
    output var  logic     miso,
    // Movement alert
    output var  logic     motion
);
    logic signed [7:0] acc_x, acc_y;
    logic [7:0]        rx_q, tx_q;
    logic              idle_q;
    int                nbit, idle_cyc, save_lvl;

    initial begin
        {acc_x, acc_y, rx_q, idle_q, motion, nbit} = '0;
        {idle_cyc, save_lvl} = '0;
        tx_q = 8'h5a;
    end
    task automatic move(input int dx, input int dy);
        acc_x = acc_x + 8'(dx);
        acc_y = acc_y + 8'(dy);
        motion = 1'b1;
    endtask : move
    always @(posedge link_clk) idle_q <= ~idle_q;
    always @(negedge spi_out.cs_n) begin
        nbit = 0;
        tx_q = 8'h5a;
    end
    always @(posedge spi_out.sclk) rx_q = {rx_q[6:0], spi_out.mosi};
    always @(negedge spi_out.sclk) begin
        nbit++;
        if (nbit % 8 == 0)
            tx_q = (rx_q == SENSOR_X_ADDR) ? acc_x : (rx_q == SENSOR_Y_ADDR) ? acc_y : 8'h5a;
        // alert dropped once counts are read out
        if (nbit == 32) {acc_x, acc_y, motion} = '0;
    end
    // power saving deepens with time since motion
    always @(posedge link_clk) begin
        idle_cyc <= motion ? 0 : idle_cyc + 1;
        save_lvl <= (idle_cyc > 64) ? 2 : ((idle_cyc > 16) ? 1 : 0);
    end
    // Released data line toggles every link cycle
    always_comb miso = spi_out.cs_n ? idle_q : tx_q[3'(7 - nbit % 8)];
endmodule : sensor_model
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for the mouse input collector
`timescale 1ns/1ps
`default_nettype none
module testbench
    import mouse_pkg::*;
;
    localparam int DEB = 20, LON = 4, LPER = 40;
    logic                      clk, sys_rst, link_clk, motion, miso;
    logic                      wheel_led, report_valid, sleeping;
    logic [2:0]                btn_n, pullup_en, buttons;
    quad_t                     wheel_phase;
    spi_out_t                  spi_out;
    motion_report_t            report;
    logic signed [WHEEL_W-1:0] wheel_count;
    int                        error_cnt, n_checks, cyc, exp_cnt, idx, k, step, dx, dy;
    int                        exp_dx[$], exp_dy[$];
    logic [1:0]                gray [4] = '{2'h0, 2'h1, 2'h3, 2'h2};

    mouse_input_collector #(.DEB_CYCLES(DEB), .LED_ON_CYCLES(LON), .LED_PER_CYCLES(LPER))
    u_mouse_input_collector (
        .clk(clk), .sys_rst(sys_rst), .link_clk(link_clk), .btn_n(btn_n),
        .wheel_phase(wheel_phase), .pullup_en(pullup_en), .wheel_led(wheel_led),
        .motion(motion), .miso(miso), .spi_out(spi_out), .buttons(buttons),
        .wheel_count(wheel_count), .report(report), .report_valid(report_valid),
        .sleeping(sleeping)
    );
    sensor_model u_sensor_model (
        .link_clk(link_clk), .spi_out(spi_out), .miso(miso), .motion(motion)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #1.3;
        forever #80 link_clk = ~link_clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            $display("unexpected timeout at %0t: %h vs %h", $time, cyc, 0);
            end_sim();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic wait_btn(input logic [2:0] v);
        for (k = 0; k < DEB + 40 && buttons !== v; k++) tick(1);
    endtask : wait_btn
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    initial begin
        {error_cnt, n_checks, cyc, exp_cnt, idx} = '0;
        sys_rst = 1'b1;
        btn_n = 3'h7;
        wheel_phase = 2'h0;
        void'($urandom(7));
        tick(120);
        sys_rst = 1'b0;
        tick(1);
        check(pullup_en, 16'h0007);
        check({buttons, sleeping, report_valid, wheel_count}, 16'h0200);
        $display("reset test done");
        for (int b = 0; b < 3; b++) begin
            btn_n[b] = 1'b0;
            tick(DEB / 2);
            btn_n[b] = 1'b1;
            tick(DEB + 5);
            check(buttons, 16'h0000);
            btn_n[b] = 1'b0;
            wait_btn(3'h1 << b);
            check(buttons, 16'h0001 << b);
            check(k >= DEB && k <= DEB + 4, 16'h0001);
            btn_n[b] = 1'b1;
            wait_btn(3'h0);
            check(buttons, 16'h0000);
            $display("button %0d test done", b);
        end
        btn_n = 3'h5;
        wait_btn(3'h2);
        check(sleeping, 16'h0000);
        for (int s = 0; s < 16; s++) begin
            step = (s == 7) ? 2 : (($urandom % 2) ? 1 : 3);
            idx = (idx + step) % 4;
            wheel_phase = gray[idx];
            if (step == 1) exp_cnt++;
            else if (step == 3) exp_cnt--;
            tick(LPER + 10);
            check({8'h00, wheel_count}, {8'h00, exp_cnt[7:0]});
        end
        $display("wheel test done");
        btn_n = 3'h7;
        tick(2 * LPER + DEB + 10);
        check(sleeping, 16'h0001);
        wheel_phase = gray[(idx + 1) % 4];
        tick(3 * LPER);
        check({8'h00, wheel_count}, {8'h00, exp_cnt[7:0]});
        $display("sleep test done");
        for (int r = 0; r < 4; r++) begin
            dx = int'($urandom_range(100)) - 50;
            dy = int'($urandom_range(100)) - 50;
            u_sensor_model.move(dx, dy);
            if (r % 2 == 1) u_sensor_model.move(dy, dx);
            exp_dx.push_back(r % 2 ? dx + dy : dx);
            exp_dy.push_back(r % 2 ? dx + dy : dy);
            for (k = 0; k < 4000 && report_valid !== 1'b1; k++) tick(1);
            check({15'h0000, report_valid}, 16'h0001);
            check({8'h00, report.dx}, {8'h00, 8'(exp_dx.pop_front())});
            check({8'h00, report.dy}, {8'h00, 8'(exp_dy.pop_front())});
            tick(200);
        end
        $display("sensor read test done");
        end_sim();
    end
endmodule : testbench
`default_nettype wire

/* rtl/button_debounce.sv */
// Debouncer for the three active-low button switches
`timescale 1ns/1ps
`default_nettype none
module button_debounce
    import mouse_pkg::*;
#(
    parameter int DEB_CYCLES = DEBOUNCE_CYC
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    // Synchronised switch levels, low when pressed
    input  wire logic [NUM_BUTTONS-1:0] btn_n_sync,
    // Accepted pressed state, high when pressed
    output var  logic [NUM_BUTTONS-1:0] pressed_q
);

    logic [NUM_BUTTONS-1:0] pressed_d;
    logic [21:0]            cnt_q [NUM_BUTTONS];
    logic [21:0]            cnt_d [NUM_BUTTONS];

    always_comb begin
        pressed_d = pressed_q;
        for (int i = 0; i < NUM_BUTTONS; i++) begin
            cnt_d[i] = '0;
            if (!btn_n_sync[i] != pressed_q[i]) begin
                if (cnt_q[i] == 22'(DEB_CYCLES - 1)) begin
                    pressed_d[i] = !btn_n_sync[i];
                end else begin
                    cnt_d[i] = cnt_q[i] + 22'h00_0001;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pressed_q <= '0;
            for (int i = 0; i < NUM_BUTTONS; i++) begin
                cnt_q[i] <= '0;
            end
        end else begin
            pressed_q <= pressed_d;
            for (int i = 0; i < NUM_BUTTONS; i++) begin
                cnt_q[i] <= cnt_d[i];
            end
        end
    end

endmodule : button_debounce
`default_nettype wire

/* rtl/mouse_input_collector.sv */
// Button, wheel and navigation sensor input collector
//
// Behaviour
// - Low button input means pressed.
// - High button input means released.
// - Debounce each button about fifteen milliseconds.
// - Three buttons: left, wheel, right.
// - Enable pull-ups on all button inputs.
// - Every one-position phase change seen while awake counts one step.
// - Previous versus current state gives direction.
// - After alert, read X, Y and report.
// - Controller is always the serial master.
// - Each serial select frame moves four bytes: X address, X data, Y address, Y data.
// - Sleep while alert inactive and buttons released, wake on alert or press.
// - Pulse wheel light 40us every 2ms while awake.
`timescale 1ns/1ps
`default_nettype none
module mouse_input_collector
    import mouse_pkg::*;
#(
    parameter int DEB_CYCLES     = DEBOUNCE_CYC,
    parameter int LED_ON_CYCLES  = LED_ON_CYC,
    parameter int LED_PER_CYCLES = LED_PERIOD_CYC
) (
    // System clock and reset
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    // Serial link clock
    input  wire logic                      link_clk,
    // Button and wheel pins
    input  wire logic [NUM_BUTTONS-1:0]    btn_n,
    input  wire quad_t                     wheel_phase,
    output var  logic [NUM_BUTTONS-1:0]    pullup_en,
    output var  logic                      wheel_led,
    // Sensor pins
    input  wire logic                      motion,
    input  wire logic                      miso,
    output var  spi_out_t                  spi_out,
    // Collected results
    output var  logic [NUM_BUTTONS-1:0]    buttons,
    output var  logic signed [WHEEL_W-1:0] wheel_count,
    output var  motion_report_t            report,
    output var  logic                      report_valid,
    output var  logic                      sleeping
);

    typedef enum logic [1:0] {
        SYS_SLEEP,
        SYS_ACTIVE,
        SYS_READ
    } sys_state_t;

    typedef enum logic {
        LNK_IDLE,
        LNK_SHIFT
    } lnk_state_t;

    // Input synchronisers, system domain
    logic [NUM_BUTTONS-1:0] btn_s1_q;
    logic [NUM_BUTTONS-1:0] btn_s2_q;
    quad_t                  quad_s1_q;
    quad_t                  quad_s2_q;
    logic                   motion_s1_q;
    logic                   motion_s2_q;
    logic                   done_s1_q;
    logic                   done_s2_q;
    logic                   done_tgl_q;
    logic signed [7:0]      x_q;
    logic signed [7:0]      y_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            btn_s1_q    <= RELEASED_N;
            btn_s2_q    <= RELEASED_N;
            quad_s1_q   <= '0;
            quad_s2_q   <= '0;
            motion_s1_q <= 1'b0;
            motion_s2_q <= 1'b0;
            done_s1_q   <= 1'b0;
            done_s2_q   <= 1'b0;
        end else begin
            btn_s1_q    <= btn_n;
            btn_s2_q    <= btn_s1_q;
            quad_s1_q   <= wheel_phase;
            quad_s2_q   <= quad_s1_q;
            motion_s1_q <= motion;
            motion_s2_q <= motion_s1_q;
            done_s1_q   <= done_tgl_q;
            done_s2_q   <= done_s1_q;
        end
    end

    button_debounce #(
        .DEB_CYCLES (DEB_CYCLES)
    ) u_debounce (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .btn_n_sync (btn_s2_q),
        .pressed_q  (buttons)
    );

    // Wheel sampling strobe from the light pulse
    logic                 sample_q;
    logic                 sample_d;

    wheel_decoder u_wheel (
        .clk     (clk),
        .sys_rst (sys_rst),
        .sample  (sample_q),
        .phase   (quad_s2_q),
        .count_q (wheel_count)
    );

    // System state, light timer and report capture
    sys_state_t           sys_q;
    sys_state_t           sys_d;
    logic [LED_CNT_W-1:0] led_cnt_q;
    logic [LED_CNT_W-1:0] led_cnt_d;
    logic                 led_q;
    logic                 led_d;
    logic                 req_tgl_q;
    logic                 req_tgl_d;
    logic                 done_seen_q;
    logic                 done_seen_d;
    motion_report_t       report_q;
    motion_report_t       report_d;
    logic                 valid_q;
    logic                 valid_d;
    logic                 sleep_q;
    logic                 sleep_d;
    logic                 period_end;

    assign period_end = (led_cnt_q == LED_CNT_W'(LED_PER_CYCLES - 1));

    always_comb begin
        sys_d       = sys_q;
        led_cnt_d   = LED_CNT_W'(LED_PER_CYCLES - 1);
        led_d       = 1'b0;
        sample_d    = 1'b0;
        req_tgl_d   = req_tgl_q;
        done_seen_d = done_seen_q;
        report_d    = report_q;
        valid_d     = 1'b0;
        case (sys_q)
            SYS_SLEEP: begin
                if (motion_s2_q) begin
                    req_tgl_d = !req_tgl_q;
                    sys_d     = SYS_READ;
                end else if (btn_s2_q != RELEASED_N) begin
                    sys_d = SYS_ACTIVE;
                end
            end
            SYS_ACTIVE: begin
                if (motion_s2_q) begin
                    req_tgl_d = !req_tgl_q;
                    sys_d     = SYS_READ;
                end else if (period_end && buttons == '0
                             && btn_s2_q == RELEASED_N) begin
                    sys_d = SYS_SLEEP;
                end
            end
            SYS_READ: begin
                if (done_s2_q != done_seen_q) begin
                    done_seen_d = done_s2_q;
                    report_d.dx = x_q;
                    report_d.dy = y_q;
                    valid_d     = 1'b1;
                    sys_d       = SYS_ACTIVE;
                end
            end
            default: sys_d = SYS_SLEEP;
        endcase
        if (sys_d != SYS_SLEEP) begin
            led_cnt_d = period_end ? '0 : led_cnt_q + LED_CNT_W'(1);
            led_d     = (led_cnt_d < LED_CNT_W'(LED_ON_CYCLES));
            sample_d  = (led_cnt_q == LED_CNT_W'(LED_ON_CYCLES - 1));
        end
        sleep_d = (sys_d == SYS_SLEEP);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sys_q       <= SYS_SLEEP;
            led_cnt_q   <= LED_CNT_W'(LED_PER_CYCLES - 1);
            led_q       <= 1'b0;
            sample_q    <= 1'b0;
            req_tgl_q   <= 1'b0;
            done_seen_q <= 1'b0;
            report_q    <= '0;
            valid_q     <= 1'b0;
            sleep_q     <= 1'b1;
        end else begin
            sys_q       <= sys_d;
            led_cnt_q   <= led_cnt_d;
            led_q       <= led_d;
            sample_q    <= sample_d;
            req_tgl_q   <= req_tgl_d;
            done_seen_q <= done_seen_d;
            report_q    <= report_d;
            valid_q     <= valid_d;
            sleep_q     <= sleep_d;
        end
    end

    // Pull-up enables held on from reset
    logic [NUM_BUTTONS-1:0] pullup_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pullup_q <= PULLUP_ALL;
        end else begin
            pullup_q <= PULLUP_ALL;
        end
    end

    assign pullup_en    = pullup_q;
    assign wheel_led    = led_q;
    assign report       = report_q;
    assign report_valid = valid_q;
    assign sleeping     = sleep_q;

    // Link domain: reset and request synchronisers
    logic lrst_s1_q;
    logic lrst_q;
    logic req_s1_q;
    logic req_s2_q;

    always_ff @(posedge link_clk) begin
        lrst_s1_q <= sys_rst;
        lrst_q    <= lrst_s1_q;
    end

    always_ff @(posedge link_clk) begin
        if (lrst_q) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
        end else begin
            req_s1_q <= req_tgl_q;
            req_s2_q <= req_s1_q;
        end
    end

    // Link domain: serial master engine
    lnk_state_t        lnk_q;
    lnk_state_t        lnk_d;
    logic              req_seen_q;
    logic              req_seen_d;
    spi_out_t          pins_q;
    spi_out_t          pins_d;
    logic              ph_q;
    logic              ph_d;
    logic [2:0]        bit_q;
    logic [2:0]        bit_d;
    logic [1:0]        byte_q;
    logic [1:0]        byte_d;
    logic [7:0]        sh_q;
    logic [7:0]        sh_d;
    logic signed [7:0] x_d;
    logic signed [7:0] y_d;
    logic              done_tgl_d;
    logic [7:0]        rx_byte;

    // Byte sent in each slot of the read sequence
    function automatic logic [7:0] tx_byte(input logic [1:0] idx);
        case (idx)
            BYTE_ADDR_X: tx_byte = SENSOR_X_ADDR;
            BYTE_ADDR_Y: tx_byte = SENSOR_Y_ADDR;
            default:     tx_byte = DUMMY_BYTE;
        endcase
    endfunction : tx_byte

    assign rx_byte = {sh_q[6:0], miso};

    always_comb begin
        lnk_d      = lnk_q;
        req_seen_d = req_seen_q;
        pins_d     = pins_q;
        ph_d       = ph_q;
        bit_d      = bit_q;
        byte_d     = byte_q;
        sh_d       = sh_q;
        x_d        = x_q;
        y_d        = y_q;
        done_tgl_d = done_tgl_q;
        case (lnk_q)
            LNK_IDLE: begin
                if (req_s2_q != req_seen_q) begin
                    req_seen_d  = req_s2_q;
                    pins_d.cs_n = 1'b0;
                    sh_d        = tx_byte(BYTE_ADDR_X);
                    pins_d.mosi = sh_d[7];
                    ph_d        = 1'b0;
                    bit_d       = '0;
                    byte_d      = BYTE_ADDR_X;
                    lnk_d       = LNK_SHIFT;
                end
            end
            LNK_SHIFT: begin
                if (!ph_q) begin
                    pins_d.sclk = 1'b1;
                    ph_d        = 1'b1;
                end else begin
                    pins_d.sclk = 1'b0;
                    ph_d        = 1'b0;
                    sh_d        = rx_byte;
                    pins_d.mosi = sh_q[6];
                    bit_d       = bit_q + 3'h1;
                    if (bit_q == LAST_BIT) begin
                        byte_d      = byte_q + 2'h1;
                        sh_d        = tx_byte(byte_d);
                        pins_d.mosi = sh_d[7];
                        if (byte_q == BYTE_DATA_X) begin
                            x_d = rx_byte;
                        end
                        if (byte_q == BYTE_DATA_Y) begin
                            y_d         = rx_byte;
                            pins_d.cs_n = 1'b1;
                            pins_d.mosi = 1'b0;
                            done_tgl_d  = !done_tgl_q;
                            lnk_d       = LNK_IDLE;
                        end
                    end
                end
            end
            default: lnk_d = LNK_IDLE;
        endcase
    end

    always_ff @(posedge link_clk) begin
        if (lrst_q) begin
            lnk_q      <= LNK_IDLE;
            req_seen_q <= 1'b0;
            pins_q     <= '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0};
            ph_q       <= 1'b0;
            bit_q      <= '0;
            byte_q     <= '0;
            sh_q       <= '0;
            x_q        <= '0;
            y_q        <= '0;
            done_tgl_q <= 1'b0;
        end else begin
            lnk_q      <= lnk_d;
            req_seen_q <= req_seen_d;
            pins_q     <= pins_d;
            ph_q       <= ph_d;
            bit_q      <= bit_d;
            byte_q     <= byte_d;
            sh_q       <= sh_d;
            x_q        <= x_d;
            y_q        <= y_d;
            done_tgl_q <= done_tgl_d;
        end
    end

    assign spi_out = pins_q;

endmodule : mouse_input_collector
`default_nettype wire

/* rtl/mouse_pkg.sv */
// Shared constants and carrier types of the mouse input collector
package mouse_pkg;

    // Clock rate of the system domain
    localparam int CLK_MHZ = 200;
    localparam int CLK_KHZ = CLK_MHZ * 1000;

    // Button debounce interval, least time rounded up
    localparam int DEBOUNCE_MS  = 15;
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;

    // Wheel light pulse width and repeat period
    localparam int LED_ON_US      = 40;
    localparam int LED_ON_CYC     = LED_ON_US * CLK_MHZ;
    localparam int LED_PERIOD_MS  = 2;
    localparam int LED_PERIOD_CYC = LED_PERIOD_MS * CLK_KHZ;
    localparam int LED_CNT_W      = 19;

    // Buttons and their positions
    localparam int NUM_BUTTONS = 3;
    localparam int BTN_LEFT    = 0;
    localparam int BTN_WHEEL   = 1;
    localparam int BTN_RIGHT   = 2;
    localparam logic [NUM_BUTTONS-1:0] PULLUP_ALL  = 3'h7;
    localparam logic [NUM_BUTTONS-1:0] RELEASED_N  = 3'h7;

    // Wheel count width
    localparam int WHEEL_W = 8;

    // Sensor register addresses and serial framing
    localparam logic [7:0] SENSOR_X_ADDR = 8'h03;
    localparam logic [7:0] SENSOR_Y_ADDR = 8'h04;
    localparam logic [7:0] DUMMY_BYTE    = 8'h00;
    localparam logic [2:0] LAST_BIT      = 3'h7;
    localparam logic [1:0] BYTE_ADDR_X   = 2'h0;
    localparam logic [1:0] BYTE_DATA_X   = 2'h1;
    localparam logic [1:0] BYTE_ADDR_Y   = 2'h2;
    localparam logic [1:0] BYTE_DATA_Y   = 2'h3;

    // Serial pins driven toward the sensor
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic mosi;
    } spi_out_t;

    // Displacement pair read from the sensor
    typedef struct packed {
        logic signed [7:0] dx;
        logic signed [7:0] dy;
    } motion_report_t;

    // Wheel phase pair
    typedef struct packed {
        logic a;
        logic b;
    } quad_t;

endpackage : mouse_pkg

/* rtl/wheel_decoder.sv */
// Quadrature decoder for the scroll wheel
`timescale 1ns/1ps
`default_nettype none
module wheel_decoder
    import mouse_pkg::*;
(
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    // Phase sample and its strobe
    input  wire logic                      sample,
    input  wire quad_t                     phase,
    // Signed wheel count
    output var  logic signed [WHEEL_W-1:0] count_q
);

    quad_t                      prev_q;
    quad_t                      prev_d;
    logic signed [WHEEL_W-1:0]  count_d;

    // Step of one transition: +1 forward, -1 backward, 0 none or invalid
    function automatic logic signed [WHEEL_W-1:0] step(input quad_t p, input quad_t c);
        logic [3:0] t;
        t = {p.a, p.b, c.a, c.b};
        case (t)
            4'h1, 4'h7, 4'hE, 4'h8: step = 8'sh01;
            4'h2, 4'hB, 4'hD, 4'h4: step = -8'sh01;
            default:                step = 8'sh00;
        endcase
    endfunction : step

    always_comb begin
        prev_d  = prev_q;
        count_d = count_q;
        if (sample) begin
            prev_d  = phase;
            count_d = count_q + step(prev_q, phase);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prev_q  <= '0;
            count_q <= '0;
        end else begin
            prev_q  <= prev_d;
            count_q <= count_d;
        end
    end

endmodule : wheel_decoder
`default_nettype wire
